// [common/trli_pkg.sv]
// Package for the ring line-interface control block
package trli_pkg;

   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [11:0] ADDR_CTRL       = 12'h000;   // Control register
   localparam logic [11:0] ADDR_STATUS     = 12'h004;   // Live line status
   localparam logic [11:0] ADDR_IRQ_STAT   = 12'h008;   // Sticky event bits
   localparam logic [11:0] ADDR_IRQ_MASK   = 12'h00C;   // Event mask
   localparam logic [11:0] ADDR_RX_DATA    = 12'h010;   // Received half-bit shifter
   localparam logic [11:0] ADDR_TX_DATA    = 12'h014;   // Transmit half-bit level
   localparam logic [11:0] ADDR_SPEED_STRAP = 12'hA0C;  // Line speed strap readback

   // ****************************************
   // Control field positions
   // ****************************************
   localparam int CTRL_ACQ_POS     = 0;   // Acquisition select
   localparam int CTRL_INSERT_POS  = 1;   // Request ring insertion
   localparam int CTRL_LOOP_POS    = 2;   // Request internal loopback
   localparam int CTRL_HOLD_POS    = 3;   // Adapter hold reset
   localparam int CTRL_SPEED_POS   = 4;   // Selected speed, 1 = 16 Mbps
   localparam int CTRL_WIDTH       = 5;   // Used control bits

   // ****************************************
   // Status and event field positions
   // ****************************************
   localparam int ST_READY_POS     = 0;   // Energy lock ready
   localparam int ST_FAULT_POS     = 1;   // Wire fault present
   localparam int ST_RXVALID_POS   = 2;   // Receive data valid
   localparam int EV_READY_LOST    = 0;   // Locked state left (ready lost, select change or hold)
   localparam int EV_READY_GAINED  = 1;   // Ready arrived
   localparam int EV_FAULT         = 2;   // Wire fault appeared
   localparam int EV_RX_BYTE       = 3;   // Eight half-bits captured
   localparam int EV_WIDTH         = 4;   // Number of events

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 5'h08;  // Hold reset on, data acquire
   localparam logic [EV_WIDTH-1:0]   MASK_RESET = 4'h0;   // All events masked

   // ****************************************
   // Carrier types
   // ****************************************
   typedef struct packed {
      logic acq_select;        // High = lock to crystal reference
      logic ring_insert_n;     // Low = insert into ring
      logic loopback_n;        // Low = internal loopback active
      logic tx_pos;            // True transmit data
      logic tx_neg;            // Inverted transmit data
   } trli_line_out_t;

   typedef struct packed {
      logic energy_lock_ready_n;  // Low = energy and lock present
      logic wire_fault_n;         // Low = wire fault
      logic rx_line_data;         // Manchester half-bit data
      logic rx_clock;             // Recovered clock
      logic elastic_buffer_clock_in; // Ring baud clock
   } trli_line_in_t;

   typedef enum logic [2:0] {
      TRLI_ST_HELD   = 3'b001,     // Adapter held in reset
      TRLI_ST_ACQ    = 3'b010,     // Waiting for energy lock
      TRLI_ST_LOCKED = 3'b100      // Receive data valid
   } trli_state_t;

endpackage : trli_pkg

// [rtl/trli_line_ctrl.sv]
// Ring line-interface control with APB registers
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps

// Function
// (R1) Acquisition select low listens, high locks crystal
// (R2) Interface drops ready after acquisition change
// (R3) Ready low means enough receive energy
// (R4) Recovered clock is one baud per period
// (R5) Data sampled on recovered clock rising edge
// (R6) Transmit data driven as complementary pair
// (R7) Insert output low activates ring insertion
// (R8) Loopback low routes transmit internally
// (R9) Wire fault low reports pair fault
// (R10) In reset: acquisition high, insert high, loopback low
// (R11) Baud clock clocks elastic buffer data out
// (R12) Recommended oscillator and divider pairings
// (R13) Hold reset bit high while changing speed
// (R14) Speed strap readable at address 0A0C
// (R15) Supports 4 or 16 Mbps, switchable; here the speed bit is only stored and read back, it drives nothing
// (R16) Resynchronise inputs; data invalid without ready
module trli_line_ctrl
   import trli_pkg::*;
(
   input  wire logic        CLK_SYS,       // System clock, 250 MHz
   input  wire logic        RST_N,         // Async reset, active low
   input  wire logic        PSEL,          // APB select
   input  wire logic        PENABLE,       // APB access phase
   input  wire logic        PWRITE,        // APB direction
   input  wire logic [11:0] PADDR,         // APB byte address
   input  wire logic [31:0] PWDATA,        // APB write data
   output logic      [31:0] PRDATA,        // APB read data
   output logic             PREADY,        // APB ready
   output logic             PSLVERR,       // APB error
   output logic             IRQ,           // Level interrupt
   input  wire trli_line_in_t  LINE_IN,    // Pins from line interface
   input  wire logic        LINE_SPEED_STRAP, // Speed strap pin
   output trli_line_out_t   LINE_OUT       // Pins to line interface
);

   // ****************************************
   // Declarations
   // ****************************************
   logic [CTRL_WIDTH-1:0] ctrl;            // Control register
   logic [EV_WIDTH-1:0]   irq_stat;        // Sticky events
   logic [EV_WIDTH-1:0]   irq_mask;        // Event mask
   logic [EV_WIDTH-1:0]   ev;              // Event pulses
   logic [4:0]            sync1;           // First sync stage
   logic [4:0]            sync2;           // Second sync stage
   logic [4:0]            sync3;           // Delayed copy for edges
   logic                  strap1;          // Strap first stage
   logic                  strap;           // Strap synchronised
   logic                  ready;           // Synced ready, active high
   logic                  fault;           // Synced fault, active high
   logic                  rclk_rise;       // Recovered clock rising edge
   logic                  bclk_rise;       // Baud clock rising edge
   logic [7:0]            rx_shift;        // Captured half-bits
   logic [2:0]            rx_count;        // Half-bits in shifter
   logic                  tx_bit;          // Transmit half-bit level
   logic                  tx_out;          // Retimed transmit level
   logic                  acq_prev;        // Last acquisition level
   trli_state_t           state;           // Line state
   trli_state_t           next_state;      // Next line state
   logic                  wr_en;           // Write strobe
   logic                  rd_en;           // Read strobe
   logic                  addr_ok;         // Mapped address

   // ****************************************
   // Input synchronisers
   // ****************************************
   // Two stages on every pin input, third for edges
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         sync1  <= 5'h1F;
         sync2  <= 5'h1F;
         sync3  <= 5'h1F;
         strap1 <= 1'b0;
         strap  <= 1'b0;
      end else begin
         sync1  <= LINE_IN;                // see (R16)
         sync2  <= sync1;
         sync3  <= sync2;
         strap1 <= LINE_SPEED_STRAP;
         strap  <= strap1;
      end
   end

   // Field picks from second stage, edges also use third
   assign ready     = ~sync2[4];           // see (R3) see (R16)
   assign fault     = ~sync2[3];           // see (R9)
   assign rclk_rise = sync2[1] & ~sync3[1];
   assign bclk_rise = sync2[0] & ~sync3[0];

   // ****************************************
   // Line state machine
   // ****************************************
   // Held while hold bit set, reacquire after select change
   always_comb begin
      next_state = state;
      case (state)
         TRLI_ST_HELD: begin
            if (!ctrl[CTRL_HOLD_POS]) begin
               next_state = TRLI_ST_ACQ;
            end
         end
         TRLI_ST_ACQ: begin
            if (ctrl[CTRL_HOLD_POS]) begin
               next_state = TRLI_ST_HELD;
            end else if (ready) begin
               next_state = TRLI_ST_LOCKED;
            end
         end
         TRLI_ST_LOCKED: begin
            if (ctrl[CTRL_HOLD_POS]) begin
               next_state = TRLI_ST_HELD;  // see (R13)
            end else if (!ready || acq_prev != ctrl[CTRL_ACQ_POS]) begin
               next_state = TRLI_ST_ACQ;   // see (R2)
            end
         end
         default: begin
            next_state = TRLI_ST_HELD;
         end
      endcase
   end

   // State register
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         state    <= TRLI_ST_HELD;
         acq_prev <= 1'b1;
      end else begin
         state    <= next_state;
         acq_prev <= ctrl[CTRL_ACQ_POS];
      end
   end

   // ****************************************
   // Receive capture
   // ****************************************
   // Sample on recovered clock rise, only while locked
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rx_shift <= 8'h00;
         rx_count <= 3'h0;
      end else if (state != TRLI_ST_LOCKED) begin
         rx_count <= 3'h0;                 // see (R16)
      end else if (rclk_rise) begin
         rx_shift <= {rx_shift[6:0], sync2[2]};   // see (R5) see (R4)
         rx_count <= rx_count + 3'h1;
      end
   end

   // ****************************************
   // Transmit retiming
   // ****************************************
   // Level updated on baud clock rising edges
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         tx_out <= 1'b0;
      end else if (bclk_rise) begin
         tx_out <= tx_bit;                 // see (R11)
      end
   end

   // ****************************************
   // Pin outputs
   // ****************************************
   // Hold bit forces the reset pin pattern
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         LINE_OUT <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};   // see (R10)
      end else if (ctrl[CTRL_HOLD_POS]) begin
         LINE_OUT <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};   // see (R10)
      end else begin
         LINE_OUT.acq_select    <= ctrl[CTRL_ACQ_POS];     // see (R1)
         LINE_OUT.ring_insert_n <= ~ctrl[CTRL_INSERT_POS]; // see (R7)
         LINE_OUT.loopback_n    <= ~ctrl[CTRL_LOOP_POS];   // see (R8)
         LINE_OUT.tx_pos        <= tx_out;                 // see (R6)
         LINE_OUT.tx_neg        <= ~tx_out;                // see (R6)
      end
   end

   // ****************************************
   // Events and interrupt
   // ****************************************
   assign ev[EV_READY_LOST]   = (state == TRLI_ST_LOCKED) && (next_state != TRLI_ST_LOCKED);
   assign ev[EV_READY_GAINED] = (state == TRLI_ST_ACQ) && (next_state == TRLI_ST_LOCKED);
   assign ev[EV_FAULT]        = sync2[3] == 1'b0 && sync3[3] == 1'b1;
   assign ev[EV_RX_BYTE]      = (state == TRLI_ST_LOCKED) && rclk_rise && rx_count == 3'h7;

   // ****************************************
   // APB slave
   // ****************************************
   assign wr_en   = PSEL && PENABLE && PWRITE;
   assign rd_en   = PSEL && PENABLE && !PWRITE;
   assign addr_ok = PADDR inside {ADDR_CTRL, ADDR_STATUS, ADDR_IRQ_STAT, ADDR_IRQ_MASK,
                                  ADDR_RX_DATA, ADDR_TX_DATA, ADDR_SPEED_STRAP};
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !addr_ok;

   // Control, mask and transmit writes
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         ctrl     <= CTRL_RESET;
         irq_mask <= MASK_RESET;
         tx_bit   <= 1'b0;
      end else if (wr_en) begin
         case (PADDR)
            ADDR_CTRL:     ctrl     <= PWDATA[CTRL_WIDTH-1:0];   // see (R15)
            ADDR_IRQ_MASK: irq_mask <= PWDATA[EV_WIDTH-1:0];
            ADDR_TX_DATA:  tx_bit   <= PWDATA[0];
            default:       ;
         endcase
      end
   end

   // Sticky status, set wins over write-one clear
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= (irq_stat & ~((wr_en && PADDR == ADDR_IRQ_STAT) ?
                     PWDATA[EV_WIDTH-1:0] : '0)) | ev;
      end
   end

   // Interrupt level from register
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(irq_stat & irq_mask);
      end
   end

   // Read data register
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         PRDATA <= 32'h0000_0000;
      end else if (PSEL && !PENABLE && !PWRITE) begin
         case (PADDR)
            ADDR_CTRL:        PRDATA <= {27'h0, ctrl};
            ADDR_STATUS:      PRDATA <= {29'h0, state == TRLI_ST_LOCKED, fault, ready};
            ADDR_IRQ_STAT:    PRDATA <= {28'h0, irq_stat};
            ADDR_IRQ_MASK:    PRDATA <= {28'h0, irq_mask};
            ADDR_RX_DATA:     PRDATA <= {24'h0, rx_shift};
            ADDR_TX_DATA:     PRDATA <= {31'h0, tx_bit};
            ADDR_SPEED_STRAP: PRDATA <= {31'h0, strap};   // see (R14)
            default:          PRDATA <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   chk_hold_pins: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      $past(ctrl[CTRL_HOLD_POS]) |-> LINE_OUT.acq_select && LINE_OUT.ring_insert_n
      && !LINE_OUT.loopback_n) else $error("hold pattern wrong");   // see (R10)
   chk_tx_pair: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !$past(ctrl[CTRL_HOLD_POS]) |-> LINE_OUT.tx_pos != LINE_OUT.tx_neg)
      else $error("tx pair not complementary");   // see (R6)
   chk_acq_follow: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !$past(ctrl[CTRL_HOLD_POS]) |-> LINE_OUT.acq_select == $past(ctrl[CTRL_ACQ_POS]))
      else $error("acquisition select not driven");   // see (R1)
   chk_insert_follow: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !$past(ctrl[CTRL_HOLD_POS]) |-> LINE_OUT.ring_insert_n == !$past(ctrl[CTRL_INSERT_POS]))
      else $error("insert not driven");   // see (R7)
   chk_loop_follow: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !$past(ctrl[CTRL_HOLD_POS]) |-> LINE_OUT.loopback_n == !$past(ctrl[CTRL_LOOP_POS]))
      else $error("loopback not driven");   // see (R8)
   chk_rx_invalid: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !ready |=> state != TRLI_ST_LOCKED) else $error("locked without ready");   // see (R16)
   chk_rx_sample: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (state == TRLI_ST_LOCKED && rclk_rise && !ctrl[CTRL_HOLD_POS] && ready)
      |=> rx_shift[0] == $past(sync2[2])) else $error("sample missed");   // see (R5)
   chk_hold_state: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      ctrl[CTRL_HOLD_POS] |=> state == TRLI_ST_HELD) else $error("hold not honoured");   // see (R13)

   // Interrupt is the registered view of unmasked sticky bits
   // One cycle of lag is expected by software
   chk_irq_level: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      IRQ == $past(|(irq_stat & irq_mask)))
      else $error("interrupt level wrong");

   // Every event pulse must land in the sticky register
   // A clear in the same cycle must not hide it
   chk_event_sticky: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (|ev) |=> (irq_stat & $past(ev)) == $past(ev))
      else $error("event lost");

   // Half-bit count restarts whenever data is not valid
   // Stops stale half-bits counting toward a byte
   chk_rx_cleared: assert property (@(posedge CLK_SYS) disable iff (!RST_N)   // see (R16)
      state != TRLI_ST_LOCKED |=> rx_count == 3'h0)
      else $error("count kept while unlocked");

   // Transmit level moves only on a baud clock rise
   // Keeps the pair aligned to the baud clock
   chk_tx_retime: assert property (@(posedge CLK_SYS) disable iff (!RST_N)   // see (R11)
      bclk_rise |=> tx_out == $past(tx_bit))
      else $error("tx level not retimed");

   // Between baud rises the level stays put
   // A host write alone must not move it
   chk_tx_steady: assert property (@(posedge CLK_SYS) disable iff (!RST_N)   // see (R11)
      !bclk_rise |=> $stable(tx_out))
      else $error("tx level moved off edge");

   // A new acquisition level forces a fresh lock
   // The interface drops ready after such a change
   chk_acq_relock: assert property (@(posedge CLK_SYS) disable iff (!RST_N)   // see (R2)
      (state == TRLI_ST_LOCKED && acq_prev != ctrl[CTRL_ACQ_POS]) |=> state != TRLI_ST_LOCKED)
      else $error("lock kept over acquisition change");

   // Ready while acquiring and released moves to locked
   // Otherwise data would never become valid
   chk_lock_ready: assert property (@(posedge CLK_SYS) disable iff (!RST_N)   // see (R16)
      (state == TRLI_ST_ACQ && ready && !ctrl[CTRL_HOLD_POS]) |=> state == TRLI_ST_LOCKED)
      else $error("lock not taken");

   // A falling wire fault line raises its sticky bit
   // Software may rely on it after a short glitch
   chk_fault_event: assert property (@(posedge CLK_SYS) disable iff (!RST_N)   // see (R9)
      (!sync2[3] && sync3[3]) |=> irq_stat[EV_FAULT])
      else $error("fault event lost");

   // Strap read returns the synchronised strap level
   // Loaded at the setup cycle of the read
   chk_strap_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N)   // see (R14)
      (PSEL && !PENABLE && !PWRITE && PADDR == ADDR_SPEED_STRAP)
      |=> PRDATA == {31'h0, $past(strap)})
      else $error("strap readback wrong");

   // Unmapped access phases report an error
   // Mapped ones must not
   chk_slverr_map: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (PSEL && PENABLE) |-> PSLVERR == !addr_ok)
      else $error("slave error wrong");

endmodule : trli_line_ctrl

// [testbench/trli_line_model.sv]
// Behavioural model of the external ring line interface
`timescale 1ns/10ps
module trli_line_model
   import trli_pkg::*;
#(
   parameter int LOCK_NS = 2000          // Energy detect plus lock time
)
(
   input  wire trli_line_out_t line_out, // Pins from the block
   input  wire logic           fault,    // Bench asks for a wire fault
   input  wire logic           rx_level, // Bench level of received half-bits
   output trli_line_in_t       line_in   // Pins to the block
);
   logic rdy_n = 1'b1;                   // Ready, low when locked
   logic rclk  = 1'b0;                   // Recovered clock
   logic bclk  = 1'b0;                   // Ring baud clock
   logic rxd   = 1'b0;                   // Received half-bit
   logic src;                            // Data source before retiming
   // ****
   // Clocks and line behaviour
   // ****
   // One baud per period
   always #16 rclk = ~rclk;
   // Baud oscillator, phase unrelated to the system clock
   initial begin
      #7;
      forever #16 bclk = ~bclk;
   end
   // Ready drops on each acquisition change until locked again
   always begin
      rdy_n = 1'b1;
      #LOCK_NS;
      rdy_n = 1'b0;
      @(line_out.acq_select);
   end
   // Loopback feeds transmit data back, no receive pair used
   assign src = line_out.loopback_n ? rx_level : line_out.tx_pos;
   // Data changes on falling edge; noise while unlocked
   always @(negedge rclk) rxd <= rdy_n ? ~rxd : src;
   // Fault pin low while a fault is present
   assign line_in = {rdy_n, ~fault, rxd, rclk, bclk};
endmodule : trli_line_model

// [testbench/trli_line_ctrl_tb.sv]
// Self-checking bench for the ring line-interface control block
`timescale 1ns/10ps
module trli_line_ctrl_tb;
   import trli_pkg::*;
   logic           CLK_SYS  = 1'b0;  // System clock
   logic           RST_N    = 1'b0;  // Reset, active low
   logic           PSEL     = 1'b0;  // APB select
   logic           PENABLE  = 1'b0;  // APB access phase
   logic           PWRITE   = 1'b0;  // APB direction
   logic [11:0]    PADDR    = '0;    // APB address
   logic [31:0]    PWDATA   = '0;    // APB write data
   logic [31:0]    PRDATA, rd;       // Read data, last taken
   logic           PREADY, PSLVERR, IRQ, err;
   logic           fault    = 1'b0;  // Model fault request
   logic           rx_level = 1'b0;  // Model receive level
   logic           strap    = 1'b0;  // Speed strap pin
   trli_line_in_t  LINE_IN;          // Model to block
   trli_line_out_t LINE_OUT;         // Block to model
   int             n_mismatch = 0;   // Failed checks
   int             tests_run  = 0;   // All checks
   always #2 CLK_SYS = ~CLK_SYS;
   trli_line_ctrl trli_line_ctrl_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .LINE_IN(LINE_IN),
      .LINE_SPEED_STRAP(strap), .LINE_OUT(LINE_OUT));
   trli_line_model trli_line_model_inst (.line_out(LINE_OUT), .fault(fault),
      .rx_level(rx_level), .line_in(LINE_IN));
   // ****
   // Tasks
   // ****
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // One APB transfer, held until PREADY is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge CLK_SYS);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge CLK_SYS);
      PENABLE <= 1'b1;
      do @(posedge CLK_SYS); while (PREADY !== 1'b1 && ++n < 100);
      if (n >= 100) n_mismatch++;
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb
   task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      cmp(rd & m, exp);
   endtask : rdc
   // Poll a register until any masked bit is set
   task automatic wait_bit(input logic [11:0] a, input logic [31:0] m);
      int n;
      n = 0;
      do apb(1'b0, a, 32'h0000_0000); while ((rd & m) == 0 && ++n < 1000);
      if (n >= 1000) n_mismatch++;
   endtask : wait_bit
   // Two fresh captures so the shifter holds only new half-bits
   task automatic rxbyte(input logic [31:0] exp);
      repeat (2) begin
         apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0008);
         wait_bit(ADDR_IRQ_STAT, 32'h0000_0008);
      end
      rdc(ADDR_RX_DATA, 32'h0000_00FF, exp);
   endtask : rxbyte
   // ****
   // Tests
   // ****
   initial begin
      repeat (16) @(posedge CLK_SYS);
      cmp({27'h0, LINE_OUT}, 32'h0000_0019);
      RST_N <= 1'b1;
      rdc(ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0008);
      rdc(ADDR_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
      apb(1'b1, ADDR_CTRL, 32'h0000_0002);
      repeat (2) @(posedge CLK_SYS);
      cmp({27'h0, LINE_OUT}, 32'h0000_0005);
      wait_bit(ADDR_STATUS, 32'h0000_0001);
      rdc(ADDR_STATUS, 32'h0000_0007, 32'h0000_0005);
      apb(1'b1, ADDR_IRQ_STAT, 32'h0000_000F);
      apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
      apb(1'b1, ADDR_CTRL, 32'h0000_0003);
      wait_bit(ADDR_IRQ_STAT, 32'h0000_0001);
      rdc(ADDR_STATUS, 32'h0000_0007, 32'h0000_0000);
      cmp({31'h0, IRQ}, 32'h0000_0001);
      apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0000);
      repeat (2) @(posedge CLK_SYS);
      cmp({31'h0, IRQ}, 32'h0000_0000);
      apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
      repeat (2) @(posedge CLK_SYS);
      cmp({31'h0, IRQ}, 32'h0000_0001);
      apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0001);
      repeat (2) @(posedge CLK_SYS);
      cmp({31'h0, IRQ}, 32'h0000_0000);
      wait_bit(ADDR_IRQ_STAT, 32'h0000_0002);
      fault <= 1'b1;
      wait_bit(ADDR_STATUS, 32'h0000_0002);
      rdc(ADDR_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
      fault <= 1'b0;
      repeat (8) @(posedge CLK_SYS);
      rdc(ADDR_STATUS, 32'h0000_0002, 32'h0000_0000);
      rx_level <= 1'b1;
      rxbyte(32'h0000_00FF);
      rx_level <= 1'b0;
      rxbyte(32'h0000_0000);
      rx_level <= 1'b1;
      apb(1'b1, ADDR_CTRL, 32'h0000_0007);
      repeat (2) @(posedge CLK_SYS);
      cmp({27'h0, LINE_OUT}, 32'h0000_0011);
      rxbyte(32'h0000_0000);
      apb(1'b1, ADDR_TX_DATA, 32'h0000_0001);
      repeat (40) @(posedge CLK_SYS);
      cmp({27'h0, LINE_OUT}, 32'h0000_0012);
      rxbyte(32'h0000_00FF);
      strap <= 1'b1;
      repeat (4) @(posedge CLK_SYS);
      rdc(ADDR_SPEED_STRAP, 32'h0000_0001, 32'h0000_0001);
      strap <= 1'b0;
      repeat (4) @(posedge CLK_SYS);
      rdc(ADDR_SPEED_STRAP, 32'h0000_0001, 32'h0000_0000);
      apb(1'b0, 12'h018, 32'h0000_0000);
      cmp({31'h0, err}, 32'h0000_0001);
      cmp({31'h0, PREADY}, 32'h0000_0001);
      cmp(rd, 32'h0000_0000);
      apb(1'b1, ADDR_CTRL, 32'h0000_001A);
      rdc(ADDR_CTRL, 32'h0000_001F, 32'h0000_001A);
      cmp({27'h0, LINE_OUT}, 32'h0000_0019);
      RST_N <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
      cmp({27'h0, LINE_OUT}, 32'h0000_0019);
      RST_N <= 1'b1;
      rdc(ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0008);
      finish_test();
   end
   // Watchdog well beyond the expected run length
   initial begin
      #200000;
      n_mismatch++;
      finish_test();
   end
endmodule : trli_line_ctrl_tb
